// ===== src/flash_opt_pkg.sv
/*
 package for the flash option and fault injection block: register offsets,
 field positions, reset values and bus carriers. assumes a 32-bit AXI4-Lite bus.
*/
package flash_opt_pkg;
	localparam logic [7:0] OPT_ADDR = 8'h00;
	localparam logic [7:0] CFG_ADDR = 8'h04;
	localparam logic [7:0] ERRCFG_ADDR = 8'h08;
	localparam logic [7:0] ERRSTAT_ADDR = 8'h0C;
	localparam logic [7:0] STAT_ADDR = 8'h10;
	localparam int CMD_IE_BIT = 7;
	localparam int IGN_SF_BIT = 4;
	localparam int FORCE_DF_BIT = 1;
	localparam int FORCE_SF_BIT = 0;
	localparam int DF_BIT = 1;
	localparam int SF_BIT = 0;
	localparam int CMD_DONE_BIT = 7;
	localparam logic [7:0] CFG_MASK = 8'h93;
	localparam logic [7:0] ERRCFG_MASK = 8'h03;
	localparam logic [7:0] CFG_RESET = 8'h00;
	localparam logic [7:0] ERRCFG_RESET = 8'h00;
	localparam logic [7:0] OPT_FAULT = 8'hFF;
	localparam logic [17:0] OPT_NV_LOC = 18'h3FF0E;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	typedef struct packed {
		logic [7:0] addr;
		logic [31:0] data;
		logic [3:0] strb;
	} wreq_s;
	typedef struct packed {
		logic sbf;
		logic dbf;
	} fault_s;
	typedef enum logic [1:0] {
		LD_IDLE = 2'b00,
		LD_WAIT = 2'b01,
		LD_DONE = 2'b11
	} load_e;
endpackage

// ===== src/opt_loader.sv
/*
 option byte loader: after reset, fetches the nonvolatile option byte and
 captures it, or all ones on a double fault. assumes the array answers with
 a one-cycle valid pulse.
*/
`timescale 1ns/100ps
module opt_loader
	import flash_opt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	output logic nvReq,
	output logic [17:0] nvAddr,
	input wire logic nvValid,
	input wire logic [7:0] nvData,
	input wire logic nvDoubleFault,
	output logic [7:0] optValue,
	output logic loaded
);
	load_e state;
	load_e next_state;
	wire captureNow = (state == LD_WAIT) && nvValid;
	always_comb begin
		next_state = state;
		case (state)
			LD_IDLE: next_state = LD_WAIT;
			LD_WAIT: if (nvValid) next_state = LD_DONE;
			LD_DONE: next_state = LD_DONE;
			default: next_state = LD_IDLE;
		endcase
	end
	always_ff @(posedge core_clk) begin
		if (rst) state <= LD_IDLE;
		else state <= next_state;
	end
	always_ff @(posedge core_clk) begin
		if (rst) begin
			optValue <= 8'h00;
			nvReq <= 1'b0;
			nvAddr <= 18'h00000;
			loaded <= 1'b0;
		end else begin
			nvReq <= (next_state == LD_WAIT) && !captureNow;
			nvAddr <= OPT_NV_LOC;
			loaded <= (next_state == LD_DONE);
			if (captureNow) optValue <= nvDoubleFault ? OPT_FAULT : nvData;
		end
	end
	optLoadFault_a: assert property (@(posedge core_clk) disable iff (rst)
		captureNow && nvDoubleFault |=> optValue == OPT_FAULT)
		else $error("option byte not all ones after double fault");
	optLoadData_a: assert property (@(posedge core_clk) disable iff (rst)
		captureNow && !nvDoubleFault |=> optValue == $past(nvData) && loaded)
		else $error("option byte not loaded from array");
endmodule // opt_loader

// ===== src/fault_flags.sv
/*
 fault flag logic: sticky single and double fault flags set by array reads,
 forced or real, cleared by write-one. assumes read strobes are one cycle.
*/
`timescale 1ns/100ps
module fault_flags
	import flash_opt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic readDone,
	input wire fault_s readFault,
	input wire logic forceSf,
	input wire logic forceDf,
	input wire logic ignoreSf,
	input wire fault_s clearFlags,
	output fault_s flags
);
	wire setSf = readDone && (forceSf || (readFault.sbf && !ignoreSf));
	wire setDf = readDone && (forceDf || readFault.dbf);
	always_ff @(posedge core_clk) begin
		if (rst) flags <= '0;
		else begin
			flags.sbf <= setSf || (flags.sbf && !clearFlags.sbf);
			flags.dbf <= setDf || (flags.dbf && !clearFlags.dbf);
		end
	end
	forceSingle_a: assert property (@(posedge core_clk) disable iff (rst)
		readDone && forceSf |=> flags.sbf)
		else $error("forced single fault flag not set");
	forceDouble_a: assert property (@(posedge core_clk) disable iff (rst)
		readDone && forceDf |=> flags.dbf)
		else $error("forced double fault flag not set");
	ignoreSingle_a: assert property (@(posedge core_clk) disable iff (rst)
		!flags.sbf && !(readDone && forceSf) ##0 ignoreSf |=> !flags.sbf)
		else $error("single fault reported while ignored");
	realDouble_a: assert property (@(posedge core_clk) disable iff (rst)
		!flags.dbf && !forceDf && !(readDone && readFault.dbf) |=> !flags.dbf)
		else $error("double fault flag set without cause");
endmodule // fault_flags

// ===== src/flash_option_and_fault_injection.sv
/*
 flash option and fault injection block: option byte, configuration and
 error configuration registers behind an AXI4-Lite slave, fault flags and
 interrupt request outputs. assumes array read and command done indications
 come from logic on core_clk.
*/
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/100ps
// Overview of operation
// - option byte is loaded from the nonvolatile location after reset is released
// - a double fault during that load sets every option bit
// - option byte is readable, writes to it are ignored
// - command done interrupt requested when enabled and done flag set
// - ignore bit suppresses real single fault reporting and its interrupt, forced single faults still set the flag
// - force double bit makes each array read set double fault flag
// - without force, only real double faults set the double flag
// - force double bit clears only by software writing zero
// - force single bit makes each array read set single fault flag
// - without force, only real single faults set the single flag
// - force single bit clears only by software writing zero
// - error configuration register enables error interrupts, read and write
module flash_option_and_fault_injection
	import flash_opt_pkg::*;
(
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	output logic nvReq,
	output logic [17:0] nvAddr,
	input wire logic nvValid,
	input wire logic [7:0] nvData,
	input wire logic nvDoubleFault,
	input wire logic readDone,
	input wire logic readSbf,
	input wire logic readDbf,
	input wire logic cmdDone,
	output logic cmdIrq,
	output logic errIrq
);
	logic [7:0] flash_config_reg;
	logic [7:0] error_config_reg;
	logic cmd_done_flag;
	logic awHeld;
	logic wHeld;
	wreq_s wr;
	fault_s error_status_reg;
	fault_s clearFlags;
	fault_s arrayFault;
	logic [7:0] option_byte_reg;
	logic loaded;

	wire cmd_done_irq_en = flash_config_reg[CMD_IE_BIT];
	wire ignore_single_fault = flash_config_reg[IGN_SF_BIT];
	wire force_double_fault = flash_config_reg[FORCE_DF_BIT];
	wire force_single_fault = flash_config_reg[FORCE_SF_BIT];
	wire single_fault_irq_en = error_config_reg[SF_BIT];
	wire double_fault_irq_en = error_config_reg[DF_BIT];

	// write channel capture: address and data taken in either order
	wire awTake = s_axi_awvalid && s_axi_awready;
	wire wTake = s_axi_wvalid && s_axi_wready;
	wire [7:0] wAddr = awTake ? s_axi_awaddr : wr.addr;
	wire [31:0] wData = wTake ? s_axi_wdata : wr.data;
	wire [3:0] wStrb = wTake ? s_axi_wstrb : wr.strb;
	wire haveAw = awTake || awHeld;
	wire haveW = wTake || wHeld;
	wire doWrite = haveAw && haveW && !s_axi_bvalid;
	wire lane0 = wStrb[0];
	wire wrCfg = doWrite && lane0 && (wAddr == CFG_ADDR);
	wire wrErrCfg = doWrite && lane0 && (wAddr == ERRCFG_ADDR);
	wire wrErrStat = doWrite && lane0 && (wAddr == ERRSTAT_ADDR);
	wire wrStat = doWrite && lane0 && (wAddr == STAT_ADDR);
	wire wMapped = (wAddr == OPT_ADDR) || (wAddr == CFG_ADDR) || (wAddr == ERRCFG_ADDR)
		|| (wAddr == ERRSTAT_ADDR) || (wAddr == STAT_ADDR);
	wire [7:0] cfgWrite = wData[7:0] & CFG_MASK;
	wire [7:0] errCfgWrite = wData[7:0] & ERRCFG_MASK;
	assign clearFlags.sbf = wrErrStat && wData[SF_BIT];
	assign clearFlags.dbf = wrErrStat && wData[DF_BIT];
	assign arrayFault.sbf = readSbf;
	assign arrayFault.dbf = readDbf;
	wire clearDone = wrStat && wData[CMD_DONE_BIT];

	// read decode
	wire arTake = s_axi_arvalid && s_axi_arready;
	wire rdOpt = s_axi_araddr == OPT_ADDR;
	wire rdCfg = s_axi_araddr == CFG_ADDR;
	wire rdErrCfg = s_axi_araddr == ERRCFG_ADDR;
	wire rdErrStat = s_axi_araddr == ERRSTAT_ADDR;
	wire rdStat = s_axi_araddr == STAT_ADDR;
	wire rMapped = rdOpt || rdCfg || rdErrCfg || rdErrStat || rdStat;
	wire [7:0] errStatByte = {6'h00, error_status_reg.dbf, error_status_reg.sbf};
	wire [7:0] statByte = {cmd_done_flag, 7'h00};
	wire [7:0] rdByte = rdOpt ? option_byte_reg :
		rdCfg ? flash_config_reg :
		rdErrCfg ? error_config_reg :
		rdErrStat ? errStatByte :
		rdStat ? statByte : 8'h00;

	wire next_errIrq = (error_status_reg.sbf && single_fault_irq_en)
		|| (error_status_reg.dbf && double_fault_irq_en);
	wire next_cmdIrq = cmd_done_flag && cmd_done_irq_en;

	opt_loader loader (
		.core_clk(core_clk),
		.rst(rst),
		.nvReq(nvReq),
		.nvAddr(nvAddr),
		.nvValid(nvValid),
		.nvData(nvData),
		.nvDoubleFault(nvDoubleFault),
		.optValue(option_byte_reg),
		.loaded(loaded)
	);

	fault_flags faults (
		.core_clk(core_clk),
		.rst(rst),
		.readDone(readDone),
		.readFault(arrayFault),
		.forceSf(force_single_fault),
		.forceDf(force_double_fault),
		.ignoreSf(ignore_single_fault),
		.clearFlags(clearFlags),
		.flags(error_status_reg)
	);

	// write address and data holding
	always_ff @(posedge core_clk) begin
		if (rst) begin
			awHeld <= 1'b0;
			wHeld <= 1'b0;
			wr <= '0;
			s_axi_awready <= 1'b0;
			s_axi_wready <= 1'b0;
		end else begin
			if (awTake) wr.addr <= s_axi_awaddr;
			if (wTake) begin
				wr.data <= s_axi_wdata;
				wr.strb <= s_axi_wstrb;
			end
			awHeld <= haveAw && !doWrite;
			wHeld <= haveW && !doWrite;
			s_axi_awready <= !(haveAw && !doWrite) && !s_axi_awready;
			s_axi_wready <= !(haveW && !doWrite) && !s_axi_wready;
		end
	end

	// write response
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= RESP_OKAY;
		end else if (doWrite) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp <= wMapped ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			flash_config_reg <= CFG_RESET;
			error_config_reg <= ERRCFG_RESET;
		end else begin
			// force bits follow software writes only
			if (wrCfg) flash_config_reg <= cfgWrite;
			if (wrErrCfg) error_config_reg <= errCfgWrite;
		end
	end

	// command done flag, set beats write-one clear
	always_ff @(posedge core_clk) begin
		if (rst) cmd_done_flag <= 1'b0;
		else cmd_done_flag <= cmdDone || (cmd_done_flag && !clearDone);
	end

	// read channel
	always_ff @(posedge core_clk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
			s_axi_rresp <= RESP_OKAY;
		end else begin
			s_axi_arready <= !s_axi_rvalid && !s_axi_arready && !s_axi_arvalid ? 1'b1 :
				(!s_axi_rvalid && !arTake);
			if (arTake) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rdata <= {24'h000000, rdByte};
				s_axi_rresp <= rMapped ? RESP_OKAY : RESP_SLVERR;
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge core_clk) begin
		if (rst) begin
			cmdIrq <= 1'b0;
			errIrq <= 1'b0;
		end else begin
			cmdIrq <= next_cmdIrq;
			errIrq <= next_errIrq;
		end
	end

	// register and flag checks
	cmdIrqFollow_a: assert property (@(posedge core_clk) disable iff (rst)
		cmd_done_flag && cmd_done_irq_en |=> cmdIrq)
		else $error("command done interrupt missing");
	cmdIrqMask_a: assert property (@(posedge core_clk) disable iff (rst)
		!cmd_done_irq_en |=> !cmdIrq)
		else $error("command done interrupt while disabled");
	cmdDoneSet_a: assert property (@(posedge core_clk) disable iff (rst)
		cmdDone |=> cmd_done_flag)
		else $error("command done flag not set");
	optNoWrite_a: assert property (@(posedge core_clk) disable iff (rst)
		loaded && $past(loaded) |-> $stable(option_byte_reg))
		else $error("option byte changed after load");
	optWriteIgnored_a: assert property (@(posedge core_clk) disable iff (rst)
		doWrite && loaded && wAddr == OPT_ADDR |=> $stable(option_byte_reg))
		else $error("option byte changed by a write");
	optReadData_a: assert property (@(posedge core_clk) disable iff (rst)
		arTake && rdOpt |=> s_axi_rdata[7:0] == $past(option_byte_reg))
		else $error("option byte read data wrong");
	forceDfHold_a: assert property (@(posedge core_clk) disable iff (rst)
		force_double_fault && !wrCfg |=> force_double_fault)
		else $error("force double bit dropped without write");
	forceDfClear_a: assert property (@(posedge core_clk) disable iff (rst)
		wrCfg && !wData[FORCE_DF_BIT] |=> !force_double_fault)
		else $error("force double bit not cleared by write");
	forceSfHold_a: assert property (@(posedge core_clk) disable iff (rst)
		force_single_fault && !wrCfg |=> force_single_fault)
		else $error("force single bit dropped without write");
	forceSfClear_a: assert property (@(posedge core_clk) disable iff (rst)
		wrCfg && !wData[FORCE_SF_BIT] |=> !force_single_fault)
		else $error("force single bit not cleared by write");
	errCfgWrite_a: assert property (@(posedge core_clk) disable iff (rst)
		wrErrCfg |=> error_config_reg == $past(errCfgWrite))
		else $error("error config write lost");
	cfgReset_a: assert property (@(posedge core_clk)
		rst |=> flash_config_reg == CFG_RESET && error_config_reg == ERRCFG_RESET)
		else $error("configuration not cleared by reset");
	errIrqGate_a: assert property (@(posedge core_clk) disable iff (rst)
		error_status_reg.dbf && double_fault_irq_en |=> errIrq)
		else $error("double fault interrupt missing");
	sfIrqGate_a: assert property (@(posedge core_clk) disable iff (rst)
		error_status_reg.sbf && single_fault_irq_en |=> errIrq)
		else $error("single fault interrupt missing");
	errIrqMask_a: assert property (@(posedge core_clk) disable iff (rst)
		!(error_status_reg.sbf && single_fault_irq_en)
		&& !(error_status_reg.dbf && double_fault_irq_en) |=> !errIrq)
		else $error("error interrupt without enabled flag");
	dfClear_a: assert property (@(posedge core_clk) disable iff (rst)
		clearFlags.dbf && !(readDone && (force_double_fault || readDbf))
		|=> !error_status_reg.dbf)
		else $error("double fault flag not cleared");
	laneRefused_a: assert property (@(posedge core_clk) disable iff (rst)
		doWrite && !lane0 |=> $stable(flash_config_reg) && $stable(error_config_reg))
		else $error("write without lane zero strobe changed a register");
	cfgUnused_a: assert property (@(posedge core_clk) disable iff (rst)
		(flash_config_reg & ~CFG_MASK) == 8'h00)
		else $error("unassigned config bit set");

	// bus protocol checks
	readiesReset_a: assert property (@(posedge core_clk)
		rst |=> !s_axi_awready && !s_axi_wready && !s_axi_arready
		&& !s_axi_bvalid && !s_axi_rvalid)
		else $error("bus outputs active after reset");
	bvalidAfterWrite_a: assert property (@(posedge core_clk) disable iff (rst)
		doWrite |=> s_axi_bvalid)
		else $error("write response missing");
	bvalidHold_a: assert property (@(posedge core_clk) disable iff (rst)
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before bready");
	rvalidHold_a: assert property (@(posedge core_clk) disable iff (rst)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped before rready");
	rdataUpper_a: assert property (@(posedge core_clk) disable iff (rst)
		s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("read data upper bits not zero");
	unmappedWrite_a: assert property (@(posedge core_clk) disable iff (rst)
		doWrite && !wMapped |=> s_axi_bresp == RESP_SLVERR)
		else $error("unmapped write not refused");
	unmappedRead_a: assert property (@(posedge core_clk) disable iff (rst)
		arTake && !rMapped |=> s_axi_rresp == RESP_SLVERR && s_axi_rdata == 32'h00000000)
		else $error("unmapped read not refused");
endmodule // flash_option_and_fault_injection

// ===== bench/tb.sv
/*
 self-checking bench for the flash option and fault injection block: drives the
 AXI4-Lite slave, the option byte fetch, array read and command done inputs.
 assumes the slave answers each AXI4-Lite request within a few cycles.
*/
`timescale 1ns/100ps
module tb
	import flash_opt_pkg::*;
;
	logic core_clk, rst, awValid, awReady, wValid, wReady, bValid, bReady;
	logic arValid, arReady, rValid, rReady, nvReq, nvValid, nvDoubleFault;
	logic readDone, readSbf, readDbf, cmdDone, cmdIrq, errIrq;
	logic [7:0] awAddr, arAddr, nvData, nvByte;
	logic [31:0] wData, rData;
	logic [3:0] wStrb;
	logic [1:0] bResp, rResp;
	logic [17:0] nvAddr;
	logic [33:0] rq[$];
	logic [1:0] bq[$];
	int mismatches = 0;
	int check_count = 0;

	flash_option_and_fault_injection dut (.core_clk(core_clk), .rst(rst),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid),
		.s_axi_wready(wReady), .s_axi_bresp(bResp), .s_axi_bvalid(bValid),
		.s_axi_bready(bReady), .s_axi_araddr(arAddr), .s_axi_arvalid(arValid),
		.s_axi_arready(arReady), .s_axi_rdata(rData), .s_axi_rresp(rResp),
		.s_axi_rvalid(rValid), .s_axi_rready(rReady), .nvReq(nvReq), .nvAddr(nvAddr),
		.nvValid(nvValid), .nvData(nvData), .nvDoubleFault(nvDoubleFault),
		.readDone(readDone), .readSbf(readSbf), .readDbf(readDbf), .cmdDone(cmdDone),
		.cmdIrq(cmdIrq), .errIrq(errIrq));

	initial begin
		core_clk = 1'b0;
	end
	always #20 core_clk = ~core_clk;

	task automatic summarize();
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask

	task automatic hang();
		mismatches++;
		summarize();
	endtask

	task automatic chk(input string name, input logic [33:0] exp, input logic [33:0] got);
		check_count++;
		if (got !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask

	// watcher: each response taken off the bus is compared with the oldest note
	always @(posedge core_clk) begin
		if (rValid === 1'b1 && rReady === 1'b1 && rq.size() > 0)
			chk("read", rq.pop_front(), {rResp, rData});
		if (bValid === 1'b1 && bReady === 1'b1 && bq.size() > 0)
			chk("bresp", {32'h0, bq.pop_front()}, {32'h0, bResp});
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
			input logic [1:0] er);
		int n;
		@(posedge core_clk);
		awAddr <= a;
		awValid <= 1'b1;
		wData <= d;
		wStrb <= s;
		wValid <= 1'b1;
		bReady <= 1'b1;
		bq.push_back(er);
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (awValid && awReady)
				awValid <= 1'b0;
			if (wValid && wReady)
				wValid <= 1'b0;
			if (bValid === 1'b1) begin
				bReady <= 1'b0;
				break;
			end
		end
		if (n == 100)
			hang();
	endtask

	task automatic rd(input logic [7:0] a, input logic [1:0] r, input logic [31:0] d);
		int n;
		@(posedge core_clk);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		rq.push_back({r, d});
		for (n = 0; n < 100; n++) begin
			@(posedge core_clk);
			if (arValid && arReady)
				arValid <= 1'b0;
			if (rValid === 1'b1) begin
				rReady <= 1'b0;
				break;
			end
		end
		if (n == 100)
			hang();
	endtask

	// one array read or command done pulse, then time for flag and irq to settle
	task automatic pulse(input logic r, input logic s, input logic d, input logic c);
		@(posedge core_clk);
		readDone <= r;
		readSbf <= s;
		readDbf <= d;
		cmdDone <= c;
		@(posedge core_clk);
		readDone <= 1'b0;
		readSbf <= 1'b0;
		readDbf <= 1'b0;
		cmdDone <= 1'b0;
		repeat (3) @(posedge core_clk);
	endtask

	task automatic boot(input logic dbf);
		int n;
		@(posedge core_clk);
		rst <= 1'b1;
		repeat (20) @(posedge core_clk);
		rst <= 1'b0;
		for (n = 0; n < 50 && nvReq !== 1'b1; n++)
			@(posedge core_clk);
		if (nvReq !== 1'b1)
			hang();
		@(posedge core_clk);
		chk("nvAddr", {16'h0, OPT_NV_LOC}, {16'h0, nvAddr});
		nvValid <= 1'b1;
		nvData <= nvByte;
		nvDoubleFault <= dbf;
		@(posedge core_clk);
		nvValid <= 1'b0;
		nvData <= ~nvByte;
		nvDoubleFault <= ~dbf;
		repeat (2) @(posedge core_clk);
		chk("nvReq", 34'h0, {33'h0, nvReq});
	endtask

	initial begin
		{rst, awValid, wValid, bReady, arValid, rReady, nvValid, nvDoubleFault} = 8'h80;
		{readDone, readSbf, readDbf, cmdDone} = 4'h0;
		{awAddr, arAddr, nvData, wData, wStrb} = 60'h0;
		void'($urandom(32'hD046));
		nvByte = 8'($urandom()) & 8'hFE;
		boot(1'b0);
		rd(OPT_ADDR, RESP_OKAY, {24'h0, nvByte});
		wr(OPT_ADDR, {24'h0, ~nvByte}, 4'hF, RESP_OKAY);
		rd(OPT_ADDR, RESP_OKAY, {24'h0, nvByte});
		rd(CFG_ADDR, RESP_OKAY, 32'h0);
		rd(ERRCFG_ADDR, RESP_OKAY, 32'h0);
		wr(CFG_ADDR, 32'hFF, 4'hF, RESP_OKAY);
		rd(CFG_ADDR, RESP_OKAY, 32'h93);
		wr(ERRCFG_ADDR, 32'($urandom()) | 32'h3, 4'hF, RESP_OKAY);
		rd(ERRCFG_ADDR, RESP_OKAY, 32'h03);
		wr(CFG_ADDR, 32'h0, 4'hE, RESP_OKAY);
		rd(CFG_ADDR, RESP_OKAY, 32'h93);
		rd(8'h20, RESP_SLVERR, 32'h0);
		wr(8'h20, 32'h0, 4'hF, RESP_SLVERR);
		pulse(1'b1, 1'b0, 1'b0, 1'b0);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h03);
		chk("errIrq", 34'h1, {33'h0, errIrq});
		wr(ERRSTAT_ADDR, 32'h03, 4'hF, RESP_OKAY);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h0);
		rd(CFG_ADDR, RESP_OKAY, 32'h93);
		chk("errIrq", 34'h0, {33'h0, errIrq});
		wr(CFG_ADDR, 32'h10, 4'hF, RESP_OKAY);
		pulse(1'b1, 1'b1, 1'b0, 1'b0);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h0);
		chk("errIrq", 34'h0, {33'h0, errIrq});
		pulse(1'b1, 1'b0, 1'b1, 1'b0);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h02);
		chk("errIrq", 34'h1, {33'h0, errIrq});
		wr(ERRSTAT_ADDR, 32'h02, 4'hF, RESP_OKAY);
		wr(CFG_ADDR, 32'h0, 4'hF, RESP_OKAY);
		pulse(1'b1, 1'b1, 1'b0, 1'b0);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h01);
		chk("errIrq", 34'h1, {33'h0, errIrq});
		wr(ERRSTAT_ADDR, 32'h01, 4'hF, RESP_OKAY);
		wr(ERRCFG_ADDR, 32'h0, 4'hF, RESP_OKAY);
		pulse(1'b1, 1'b1, 1'b1, 1'b0);
		rd(ERRSTAT_ADDR, RESP_OKAY, 32'h03);
		chk("errIrq", 34'h0, {33'h0, errIrq});
		wr(ERRSTAT_ADDR, 32'h03, 4'hF, RESP_OKAY);
		wr(CFG_ADDR, 32'h80, 4'hF, RESP_OKAY);
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		chk("cmdIrq", 34'h1, {33'h0, cmdIrq});
		wr(STAT_ADDR, 32'h80, 4'hF, RESP_OKAY);
		repeat (2) @(posedge core_clk);
		chk("cmdIrq", 34'h0, {33'h0, cmdIrq});
		wr(CFG_ADDR, 32'h0, 4'hF, RESP_OKAY);
		pulse(1'b0, 1'b0, 1'b0, 1'b1);
		chk("cmdIrq", 34'h0, {33'h0, cmdIrq});
		wr(CFG_ADDR, 32'h93, 4'hF, RESP_OKAY);
		boot(1'b1);
		rd(OPT_ADDR, RESP_OKAY, {24'h0, OPT_FAULT});
		rd(CFG_ADDR, RESP_OKAY, 32'h0);
		rd(ERRCFG_ADDR, RESP_OKAY, 32'h0);
		repeat (2) @(posedge core_clk);
		summarize();
	end
endmodule // tb
